// [shared/ovt_pkg.sv]
// Constants shared by the overtemperature fault supervisor
package ovt_pkg;
  // Command codes of the two registers and the store and restore commands
  localparam logic [7:0] CMD_FAULT_THRESHOLD = 8'h4F;
  localparam logic [7:0] CMD_FAULT_ACTION = 8'h50;
  localparam logic [7:0] CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
  // Threshold word layout: read-only exponent above an 11-bit mantissa
  localparam int THR_MANT_W = 11;
  localparam int THR_EXP_LSB = 11;
  localparam logic [4:0] THR_EXPONENT = 5'h00;
  localparam logic [10:0] THR_RESET = 11'h091;
  // Action byte layout
  localparam int ACT_SEL_BIT = 7;
  localparam int ACT_ZERO_BIT = 6;
  localparam int ACT_POL_MSB = 5;
  localparam int ACT_POL_LSB = 3;
  localparam logic [7:0] ACT_RESET = 8'h3F;
  localparam logic [2:0] POL_NONE = 3'h0;
  localparam logic [2:0] POL_ENDLESS = 3'h7;
  // Hysteresis below the threshold before the fault flag releases
  localparam logic [11:0] HYST_DEG_C = 12'h014;
  // Retry delay is this many rise-time periods
  localparam logic [2:0] RETRY_MULT = 3'h7;
  // Timing: rise time is programmed in whole milliseconds
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  // Nonvolatile word: {select, policy, threshold mantissa}
  localparam int NV_W = 13;
  localparam int NV_DEPTH = 2;
  localparam int NV_AW = 1;
  localparam logic [0:0] NV_ADDR_CFG = 1'h0;
  localparam logic [12:0] NV_RESET = 13'h0891;
  // Response sequencer states
  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_HALT,
    ST_WAIT
  } ovt_state_t;
endpackage

// [verilog/ovt_nvm.sv]
// Small nonvolatile configuration store with registered read data
`timescale 1ns/1ps
`default_nettype none
module ovt_nvm
  import ovt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Write port
  input wire logic wr_en,
  input wire logic [NV_AW-1:0] wr_addr,
  input wire logic [NV_W-1:0] wr_data,
  // Read port
  input wire logic [NV_AW-1:0] rd_addr,
  output logic [NV_W-1:0] rd_data_ff
);
  logic [NV_W-1:0] mem_ff [NV_DEPTH];

  // Each entry starts from the factory image; contents survive soft resets
  // only in the real part, here reset stands in for the factory load
  genvar gi;
  generate
    for (gi = 0; gi < NV_DEPTH; gi = gi + 1) begin : g_entry
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          mem_ff[gi] <= NV_RESET;
        end else if (wr_en && wr_addr == NV_AW'(gi)) begin
          mem_ff[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // Registered read, one cycle of latency
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_data_ff <= NV_RESET;
    end else begin
      rd_data_ff <= mem_ff[rd_addr];
    end
  end
endmodule
`default_nettype wire

// [verilog/ovt_supervisor.sv]
// Overtemperature fault detection, status, alert and shutdown response
// Summary of operation
// R1: Fault when sensor reading exceeds threshold
// R2: Threshold not above warning sets error flags
// R3: Store command saves threshold and action
// R4: Threshold exponent reads zero, one degree steps
// R5: Threshold mantissa resets to 145
// R6: Host keeps threshold between 120 and 165
// R7: Fault sets summary, fault flag, alert
// R8: Flag holds until 20 degrees below threshold
// R9: Select bit 7 resets zero; bit 6 zero
// R10: Select zero keeps regulating, still flags, alerts
// R11: Select one shuts down, retries per policy
// R12: Policy 000 stays off until fault cleared
// R13: Policy 111 retries soft start endlessly
// R14: Other policy patterns rejected with error flags
// R15: Only policy bit 5 is stored
// R16: Delay bits mirror policy bit 5
// R17: Delay 000 only with no-restart policy
// R18: Delay 111 waits seven rise times
// R19: Bandgap faults always shut down, restart cooled
// R20: Policy and delay also govern bandgap faults
// R21: Rise time is the programmed ramp interval
// R22: Comparison re-evaluated on every new sample
// R23: Delay counter restarts at every shutdown
`timescale 1ns/1ps
`default_nettype none
module ovt_supervisor
  import ovt_pkg::*;
#(
  parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Command port from the bus front end
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] rd_data_ff,
  // Temperature sensor samples and bandgap detector pin
  input wire logic temp_valid,
  input wire logic [10:0] temp_deg_c,
  input wire logic bandgap_ot,
  // Neighbouring configuration and control
  input wire logic [10:0] overtemp_warning_threshold,
  input wire logic [6:0] rise_time_ms,
  input wire logic alert_mask,
  input wire logic clear_faults,
  input wire logic power_on_cmd,
  // Status and alert
  output logic temp_summary_bit_ff,
  output logic overtemp_fault_flag_ff,
  output logic comm_error_ff,
  output logic invalid_data_ff,
  output logic alert_ff,
  // Converter control
  output logic output_enable_ff,
  output logic soft_start_ff
);
  ovt_state_t state_ff, nxt_state;
  logic [10:0] threshold_ff;
  logic shutdown_select_ff;
  logic retry_policy_ff;
  logic bg_meta_ff, bg_sync_ff;
  logic restore_pend_ff;
  logic [NV_W-1:0] nv_rd_data;
  logic [31:0] tick_cnt_ff;
  logic [9:0] ms_cnt_ff;
  logic [9:0] dly_target;
  logic [6:0] rise_eff;
  logic wr_thr, wr_act, thr_ok, act_ok, bad_write;
  logic rd_thr, rd_act, do_store, do_load;
  logic over_thr, cooled, ot_trip, fault_any, ms_tick, dly_done;
  logic [2:0] wr_policy;
  logic [7:0] action_byte;

  // Command decode
  assign wr_thr = cmd_valid && cmd_write && cmd_code == CMD_FAULT_THRESHOLD;
  assign wr_act = cmd_valid && cmd_write && cmd_code == CMD_FAULT_ACTION;
  assign rd_thr = cmd_valid && !cmd_write && cmd_code == CMD_FAULT_THRESHOLD;
  assign rd_act = cmd_valid && !cmd_write && cmd_code == CMD_FAULT_ACTION;
  assign do_store = cmd_valid && cmd_code == CMD_STORE_ALL;
  assign wr_policy = cmd_wdata[ACT_POL_MSB:ACT_POL_LSB];
  // The range 120..165 is left to the host; only the warning order is checked
  assign thr_ok = cmd_wdata[THR_MANT_W-1:0] > overtemp_warning_threshold; // R2
  assign act_ok = wr_policy == POL_NONE || wr_policy == POL_ENDLESS; // R14
  assign bad_write = (wr_thr && !thr_ok) || (wr_act && !act_ok);
  assign do_load = restore_pend_ff;

  // Bandgap detector is asynchronous to mclk
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bg_meta_ff <= 1'b0;
      bg_sync_ff <= 1'b0;
    end else begin
      bg_meta_ff <= bandgap_ot;
      bg_sync_ff <= bg_meta_ff;
    end
  end

  // Restore reads the store one cycle before the registers load
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      restore_pend_ff <= 1'b0;
    end else begin
      restore_pend_ff <= cmd_valid && cmd_code == CMD_RESTORE_ALL;
    end
  end

  // Threshold mantissa; a rejected write leaves the old value
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      threshold_ff <= THR_RESET; // R5
    end else if (do_load) begin
      threshold_ff <= nv_rd_data[THR_MANT_W-1:0];
    end else if (wr_thr && thr_ok) begin
      threshold_ff <= cmd_wdata[THR_MANT_W-1:0];
    end
  end

  // Action bits; one flop holds all three identical policy bits
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      shutdown_select_ff <= ACT_RESET[ACT_SEL_BIT]; // R9
      retry_policy_ff <= ACT_RESET[ACT_POL_MSB];
    end else if (do_load) begin
      shutdown_select_ff <= nv_rd_data[NV_W-1];
      retry_policy_ff <= nv_rd_data[NV_W-2];
    end else if (wr_act && act_ok) begin
      shutdown_select_ff <= cmd_wdata[ACT_SEL_BIT];
      retry_policy_ff <= cmd_wdata[ACT_POL_MSB]; // R15
    end
  end

  // Nonvolatile copy of threshold, select and policy bit 5
  ovt_nvm u_nvm (
    .mclk(mclk),
    .nrst(nrst),
    .wr_en(do_store), // R3
    .wr_addr(NV_ADDR_CFG),
    .wr_data({shutdown_select_ff, retry_policy_ff, threshold_ff}),
    .rd_addr(NV_ADDR_CFG),
    .rd_data_ff(nv_rd_data)
  );

  // Read image of the action byte: bit 6 zero, delay mirrors policy
  assign action_byte = {shutdown_select_ff, 1'b0, {3{retry_policy_ff}},
                        {3{retry_policy_ff}}}; // R16

  // Read data register; unknown codes read zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_data_ff <= 16'h0000;
    end else if (rd_thr) begin
      rd_data_ff <= {THR_EXPONENT, threshold_ff}; // R4
    end else if (rd_act) begin
      rd_data_ff <= {8'h00, action_byte};
    end else if (cmd_valid && !cmd_write) begin
      rd_data_ff <= 16'h0000;
    end
  end

  // Compare on each sample so a new threshold acts on the next one
  assign over_thr = temp_valid && temp_deg_c > threshold_ff; // R1 R22
  // Widened sum avoids wrap when the reading is above 2027
  assign cooled = temp_valid &&
                  ({1'b0, temp_deg_c} + HYST_DEG_C) <= {1'b0, threshold_ff};
  assign ot_trip = over_thr && !overtemp_fault_flag_ff;

  // Fault flag with hysteresis
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      overtemp_fault_flag_ff <= 1'b0;
    end else if (over_thr) begin
      overtemp_fault_flag_ff <= 1'b1; // R7
    end else if (cooled) begin
      overtemp_fault_flag_ff <= 1'b0; // R8
    end
  end

  // Sticky summary bit; a trip in the clearing cycle wins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      temp_summary_bit_ff <= 1'b0;
    end else if (ot_trip) begin
      temp_summary_bit_ff <= 1'b1; // R7 R10
    end else if (clear_faults) begin
      temp_summary_bit_ff <= 1'b0;
    end
  end

  // Communication error and invalid data flags
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      comm_error_ff <= 1'b0;
      invalid_data_ff <= 1'b0;
    end else if (bad_write) begin
      comm_error_ff <= 1'b1; // R2 R14
      invalid_data_ff <= 1'b1;
    end else if (clear_faults) begin
      comm_error_ff <= 1'b0;
      invalid_data_ff <= 1'b0;
    end
  end

  // Alert line, suppressed while masked
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      alert_ff <= 1'b0;
    end else if ((ot_trip || bad_write) && !alert_mask) begin
      alert_ff <= 1'b1; // R7 R10
    end else if (clear_faults) begin
      alert_ff <= 1'b0;
    end
  end

  // Bandgap faults bypass the ignore choice
  assign fault_any = (overtemp_fault_flag_ff && shutdown_select_ff) ||
                     bg_sync_ff; // R11 R19

  // Retry delay in milliseconds; a zero rise time acts as the 1 ms minimum
  assign rise_eff = (rise_time_ms == 7'h00) ? 7'h01 : rise_time_ms; // R21
  assign dly_target = 10'(rise_eff * RETRY_MULT); // R18
  assign ms_tick = tick_cnt_ff == 32'(CYCLES_PER_MS - 1);
  assign dly_done = ms_cnt_ff == dly_target;

  // Response sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF: begin
        if (power_on_cmd) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!power_on_cmd) begin
          nxt_state = ST_OFF;
        end else if (fault_any) begin
          nxt_state = retry_policy_ff ? ST_WAIT : ST_HALT; // R11 R20
        end
      end
      ST_HALT: begin
        // Stays off until the fault is gone and cleared, or power is cycled
        if (!power_on_cmd) begin
          nxt_state = ST_OFF;
        end else if (clear_faults && !fault_any) begin
          nxt_state = ST_OFF; // R12 R17
        end
      end
      ST_WAIT: begin
        if (!power_on_cmd) begin
          nxt_state = ST_OFF;
        end else if (dly_done && !bg_sync_ff) begin
          nxt_state = ST_RUN; // R13 R18
        end
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Delay counters; bandgap still hot at the end restarts the wait
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_ff <= 32'h0000_0000;
      ms_cnt_ff <= 10'h000;
    end else if (state_ff != ST_WAIT || (dly_done && bg_sync_ff)) begin
      tick_cnt_ff <= 32'h0000_0000; // R23
      ms_cnt_ff <= 10'h000;
    end else if (!dly_done) begin
      if (ms_tick) begin
        tick_cnt_ff <= 32'h0000_0000;
        ms_cnt_ff <= ms_cnt_ff + 10'h001;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      end
    end
  end

  // Converter controls follow the next state so they line up with it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      output_enable_ff <= 1'b0;
      soft_start_ff <= 1'b0;
    end else begin
      output_enable_ff <= nxt_state == ST_RUN; // R10 R11
      soft_start_ff <= nxt_state == ST_RUN && state_ff != ST_RUN; // R13
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // A sample while the flag is already latched is not a new fault
  thr_trip_a: assert property ( // R1 R7
    ot_trip && !alert_mask |=> overtemp_fault_flag_ff && alert_ff &&
      temp_summary_bit_ff)
    else $error("threshold crossing did not raise flag and alert");

  thr_reject_a: assert property ( // R2
    wr_thr && !thr_ok |=> comm_error_ff && invalid_data_ff &&
      $stable(threshold_ff))
    else $error("bad threshold write not rejected");

  exp_zero_a: assert property ( // R4
    rd_thr |=> rd_data_ff[15:THR_EXP_LSB] == THR_EXPONENT &&
      rd_data_ff[10:0] == $past(threshold_ff))
    else $error("threshold read image wrong");

  hyst_hold_a: assert property ( // R8
    overtemp_fault_flag_ff && !cooled |=> overtemp_fault_flag_ff)
    else $error("fault flag released before cooling");

  bit6_zero_a: assert property ( // R9
    rd_act |=> rd_data_ff[ACT_ZERO_BIT] == 1'b0 &&
      rd_data_ff[ACT_SEL_BIT] == $past(shutdown_select_ff))
    else $error("action read bit 6 or select wrong");

  delay_mirror_a: assert property ( // R16
    rd_act |=> rd_data_ff[2:0] == {3{rd_data_ff[ACT_POL_MSB]}})
    else $error("delay bits do not mirror policy");

  ignore_run_a: assert property ( // R10
    state_ff == ST_RUN && power_on_cmd && !shutdown_select_ff &&
      !bg_sync_ff |=> output_enable_ff)
    else $error("ignore mode stopped regulating");

  fault_shut_a: assert property ( // R11
    state_ff == ST_RUN && fault_any |=> !output_enable_ff)
    else $error("fault did not shut output down");

  halt_hold_a: assert property ( // R12
    state_ff == ST_HALT && power_on_cmd && !clear_faults |=>
      state_ff == ST_HALT && !output_enable_ff)
    else $error("no-restart policy left halt");

  // Set wins over a clear in the same cycle, unless the alert is masked
  policy_reject_a: assert property ( // R14
    wr_act && !act_ok |=> comm_error_ff && invalid_data_ff &&
      alert_ff == $past(!alert_mask || (alert_ff && !clear_faults)) &&
      $stable(retry_policy_ff))
    else $error("bad policy write not rejected");

  retry_delay_a: assert property ( // R18
    state_ff == ST_WAIT && nxt_state == ST_RUN |->
      ms_cnt_ff == 10'(rise_eff * RETRY_MULT))
    else $error("restart before full retry delay");

  restart_cnt_a: assert property ( // R23
    state_ff == ST_RUN && nxt_state == ST_WAIT |=>
      ms_cnt_ff == 10'h000 && tick_cnt_ff == 32'h0000_0000)
    else $error("retry delay counter not restarted");
endmodule
`default_nettype wire

// [dv/ovt_host.sv]
// Host model that issues configuration and status commands
`timescale 1ns/1ps
`default_nettype none
module ovt_host
  import ovt_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Command port towards the supervisor
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] rd_data_ff
);
  // Idle bus shows a changing pattern, so stale data never looks valid
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // One-cycle strobe per command, launched at the falling edge
  task automatic write_cmd(input logic [7:0] code, input logic [15:0] data);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_write = 1'b1;
    cmd_code = code;
    cmd_wdata = data;
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_wdata = ~data;
  endtask

  // Read data is registered at the taking edge, picked up one half later
  task automatic read_cmd(input logic [7:0] code, output logic [15:0] data);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_write = 1'b0;
    cmd_code = code;
    @(negedge mclk);
    cmd_valid = 1'b0;
    data = rd_data_ff;
  endtask
endmodule
`default_nettype wire

// [dv/overtemp_fault_limit_response_bench.sv]
// Self-checking bench for the overtemperature fault supervisor
`timescale 1ns/1ps
`default_nettype none
module overtemp_fault_limit_response_bench
  import ovt_pkg::*;
;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid, cmd_write;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rd_data;
  logic temp_valid = 1'b0;
  logic [10:0] temp_deg_c = 11'h000;
  logic bandgap_ot = 1'b0;
  logic [10:0] warn_thr = 11'h078;
  logic [6:0] rise_ms = 7'h01;
  logic alert_mask = 1'b0;
  logic clear_faults = 1'b0;
  logic power_on_cmd = 1'b1;
  logic summ, flag, cerr, ivd, alert, oe, sst;
  logic [15:0] rv;
  int n_mismatch = 0;
  int checked = 0;
  int n;

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // Short millisecond so a retry delay is 7 * rise * 4 cycles
  ovt_supervisor #(.CYCLES_PER_MS(4)) ovt_supervisor_i (
    .mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data_ff(rd_data),
    .temp_valid(temp_valid), .temp_deg_c(temp_deg_c),
    .bandgap_ot(bandgap_ot), .overtemp_warning_threshold(warn_thr),
    .rise_time_ms(rise_ms), .alert_mask(alert_mask),
    .clear_faults(clear_faults), .power_on_cmd(power_on_cmd),
    .temp_summary_bit_ff(summ), .overtemp_fault_flag_ff(flag),
    .comm_error_ff(cerr), .invalid_data_ff(ivd), .alert_ff(alert),
    .output_enable_ff(oe), .soft_start_ff(sst));

  ovt_host ovt_host_i (
    .mclk(mclk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data_ff(rd_data));

  // Status packed as {summary, flag, comm error, invalid, alert, enable}
  function automatic logic [15:0] status();
    return {10'h000, summ, flag, cerr, ivd, alert, oe};
  endfunction

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_check(input logic [7:0] code, input logic [15:0] exp);
    ovt_host_i.read_cmd(code, rv);
    check("read data", rv, exp);
  endtask

  // Sample lands at one edge and sets the flag; enable follows one edge later, before return
  task automatic sample(input logic [10:0] t);
    @(negedge mclk);
    temp_valid = 1'b1;
    temp_deg_c = t;
    @(negedge mclk);
    temp_valid = 1'b0;
    @(negedge mclk);
  endtask

  task automatic clr();
    @(negedge mclk);
    clear_faults = 1'b1;
    @(negedge mclk);
    clear_faults = 1'b0;
    @(negedge mclk);
  endtask

  // Bounded wait for a start attempt; n is the cycle count seen
  task automatic wait_start(input int limit);
    n = 0;
    while (sst !== 1'b1 && n < limit) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #300000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    check("reset status", status(), 16'h0001);
    rd_check(CMD_FAULT_THRESHOLD, 16'h0091);
    rd_check(CMD_FAULT_ACTION, 16'h003F);
    $display("test reset done");

    // Threshold equal to warning is refused, value kept
    ovt_host_i.write_cmd(CMD_FAULT_THRESHOLD, 16'h0078);
    check("bad threshold", status(), 16'h000F);
    rd_check(CMD_FAULT_THRESHOLD, 16'h0091);
    clr();
    alert_mask = 1'b1;
    ovt_host_i.write_cmd(CMD_FAULT_THRESHOLD, 16'h0078);
    check("masked alert", status(), 16'h000D);
    alert_mask = 1'b0;
    clr();
    ovt_host_i.write_cmd(CMD_FAULT_THRESHOLD, 16'hF8A5);
    rd_check(CMD_FAULT_THRESHOLD, 16'h00A5);
    ovt_host_i.write_cmd(CMD_FAULT_THRESHOLD, 16'hF896);
    rd_check(CMD_FAULT_THRESHOLD, 16'h0096);
    for (int p = 1; p < 7; p++) begin
      ovt_host_i.write_cmd(CMD_FAULT_ACTION, 16'(p << 3));
      check("bad policy", status(), 16'h000F);
      clr();
    end
    rd_check(CMD_FAULT_ACTION, 16'h003F);
    $display("test writes done");

    // Ignore mode: trip above threshold only, release 20 below
    sample(11'd150);
    check("at threshold", status(), 16'h0001);
    sample(11'd151);
    check("ignore trip", status(), 16'h0033);
    sample(11'd131);
    check("hysteresis", status(), 16'h0033);
    sample(11'd130);
    check("released", status(), 16'h0023);
    clr();
    $display("test ignore done");

    // Shutdown without restart until cleared
    ovt_host_i.write_cmd(CMD_FAULT_ACTION, 16'h00C7);
    rd_check(CMD_FAULT_ACTION, 16'h0080);
    sample(11'd151);
    check("halt trip", status(), 16'h0032);
    wait_start(60);
    check("no restart", 16'(n), 16'd60);
    sample(11'd125);
    clr();
    wait_start(10);
    check("restart after clear", 16'(n < 10), 16'h0001);
    @(negedge mclk);
    check("running", status(), 16'h0001);
    $display("test halt done");

    // Endless retry after seven rise times
    ovt_host_i.write_cmd(CMD_FAULT_ACTION, 16'h00F8);
    rd_check(CMD_FAULT_ACTION, 16'h00BF);
    sample(11'd151);
    check("retry trip", status(), 16'h0032);
    wait_start(200);
    check("retry delay", 16'(n >= 26 && n <= 31), 16'h0001);
    sample(11'd125);
    wait_start(200);
    check("second attempt", 16'(n < 200), 16'h0001);
    repeat (3) @(negedge mclk);
    check("retry running", status(), 16'h0023);
    clr();
    $display("test retry done");

    // Bandgap fault shuts down even in ignore mode; rise time now 2 ms
    rise_ms = 7'h02;
    ovt_host_i.write_cmd(CMD_FAULT_ACTION, 16'h0038);
    rd_check(CMD_FAULT_ACTION, 16'h003F);
    bandgap_ot = 1'b1;
    repeat (5) @(negedge mclk);
    check("bandgap off", status(), 16'h0000);
    bandgap_ot = 1'b0;
    wait_start(200);
    check("bandgap restart", 16'(n >= 54 && n <= 59), 16'h0001);
    repeat (2) @(negedge mclk);
    check("bandgap running", status(), 16'h0001);
    $display("test bandgap done");

    // Store then restore brings back the saved pair
    ovt_host_i.write_cmd(CMD_FAULT_THRESHOLD, 16'h00A0);
    ovt_host_i.write_cmd(CMD_FAULT_ACTION, 16'h0080);
    ovt_host_i.write_cmd(CMD_STORE_ALL, 16'h0000);
    ovt_host_i.write_cmd(CMD_FAULT_THRESHOLD, 16'h009B);
    ovt_host_i.write_cmd(CMD_FAULT_ACTION, 16'h0038);
    ovt_host_i.write_cmd(CMD_RESTORE_ALL, 16'h0000);
    repeat (3) @(negedge mclk);
    rd_check(CMD_FAULT_THRESHOLD, 16'h00A0);
    rd_check(CMD_FAULT_ACTION, 16'h0080);
    $display("test store done");
    give_verdict();
  end
endmodule
`default_nettype wire
